// *** design/battery_undervoltage_monitor.sv ***
// Chosen here: the register addresses and the plain strobed port.
`timescale 1ns/10ps
module battery_undervoltage_monitor #(
  parameter int FILT_CYCLES = batt_mon_pkg::FILT_CYC,
  parameter int WIN_S_CYC   = batt_mon_pkg::WIN_SHORT_CYC,
  parameter int WIN_L_CYC   = batt_mon_pkg::WIN_LONG_CYC
) (
  // clock and reset
  input  wire logic                          mclk,
  input  wire logic                          sys_rst,
  // register port
  input  wire logic [batt_mon_pkg::ADDR_W-1:0] addr,
  input  wire logic [31:0]                   wdata,
  input  wire logic                          wr,
  input  wire logic                          rd,
  output logic      [31:0]                   rdata,
  // analog comparators and control pins
  input  wire logic                          batt_low_cmp,
  input  wire logic                          logic_supply_fault,
  input  wire logic                          drive_input_a,
  input  wire logic                          drive_input_b,
  // bridge
  output logic                               hs_a,
  output logic                               ls_a,
  output logic                               hs_b,
  output logic                               ls_b,
  output logic                               bridge_en,
  // disable pin (open drain)
  input  wire logic                          dis_n_in,
  output logic                               dis_n_out,
  output logic                               dis_n_oe
);
  import batt_mon_pkg::*;

  initial begin
    if (FILT_CYCLES < 1 || WIN_S_CYC < 1 || WIN_L_CYC < WIN_S_CYC)
      $error("bad timing parameters");
  end

  localparam int CW = $clog2(WIN_L_CYC + 1);
  localparam int FW = $clog2(FILT_CYCLES + 1);

  // ****************************************
  // input synchronisers
  // ****************************************
  logic [4:0] s1_r;
  logic [4:0] s2_r;
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      s1_r <= 5'h0;
      s2_r <= 5'h0;
    end else begin
      s1_r <= {dis_n_in, logic_supply_fault, drive_input_b,
               drive_input_a, batt_low_cmp};
      s2_r <= s1_r;
    end
  end
  logic cmp_s, lsf_s, ina_s, inb_s;
  assign cmp_s = s2_r[0];
  assign ina_s = s2_r[1];
  assign inb_s = s2_r[2];
  assign lsf_s = s2_r[3];

  // ****************************************
  // configuration
  // ****************************************
  logic win_sel_r, guard_en_r, drv_mode_r;
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      win_sel_r  <= 1'b0;
      guard_en_r <= 1'b0;
    end else if (wr && addr == ADDR_CFG) begin
      win_sel_r  <= wdata[CFG_WIN_BIT];
      guard_en_r <= wdata[CFG_GUARD_BIT];
    end
  end
  always_ff @(posedge mclk) begin
    if (sys_rst)
      drv_mode_r <= 1'b0;
    else if (wr && addr == ADDR_DRIVE)
      drv_mode_r <= wdata[DRV_MODE_BIT];
  end
  logic clr_wr;
  assign clr_wr = wr && addr == ADDR_CLEAR;

  // ****************************************
  // glitch filter, both directions
  // ****************************************
  logic          low_now_r;
  logic [FW-1:0] filt_cnt_r;
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      low_now_r  <= 1'b0;
      filt_cnt_r <= '0;
    end else if (cmp_s == low_now_r) begin
      filt_cnt_r <= '0;
    end else if (filt_cnt_r == FW'(FILT_CYCLES - 1)) begin
      low_now_r  <= cmp_s;
      filt_cnt_r <= '0;
    end else begin
      filt_cnt_r <= filt_cnt_r + 1'b1;
    end
  end
  logic low_q_r, low_event;
  always_ff @(posedge mclk) begin
    if (sys_rst) low_q_r <= 1'b0;
    else         low_q_r <= low_now_r;
  end
  assign low_event = low_now_r && !low_q_r;

  // ****************************************
  // sticky flags, set wins over clear
  // ****************************************
  logic low_latch_r, count_hit_r, hit_set;
  always_ff @(posedge mclk) begin
    if (sys_rst)
      low_latch_r <= 1'b0;
    else if (low_event)
      low_latch_r <= 1'b1;
    else if (clr_wr && wdata[CLR_LOW_LATCH])
      low_latch_r <= 1'b0;
  end
  always_ff @(posedge mclk) begin
    if (sys_rst)
      count_hit_r <= 1'b0;
    else if (hit_set)
      count_hit_r <= 1'b1;
    else if (clr_wr && wdata[CLR_COUNT_HIT])
      count_hit_r <= 1'b0;
  end

  // ****************************************
  // event window counter
  // ****************************************
  logic          win_act_r;
  logic [CW-1:0] win_cnt_r;
  logic [CW-1:0] win_len;
  assign win_len = win_sel_r ? CW'(WIN_L_CYC) : CW'(WIN_S_CYC);
  assign hit_set = guard_en_r && low_event && win_act_r;
  always_ff @(posedge mclk) begin
    if (sys_rst || !guard_en_r) begin
      win_act_r <= 1'b0;
      win_cnt_r <= '0;
    end else if (low_event && !win_act_r) begin
      win_act_r <= 1'b1;
      win_cnt_r <= '0;
    end else if (win_act_r) begin
      if (low_event || win_cnt_r == win_len - 1'b1) begin
        win_act_r <= 1'b0;
        win_cnt_r <= '0;
      end else begin
        win_cnt_r <= win_cnt_r + 1'b1;
      end
    end
  end

  // ****************************************
  // functional state
  // ****************************************
  bridge_state_t state_r;
  always_ff @(posedge mclk) begin
    if (sys_rst)
      state_r <= ST_NORMAL;
    else unique case (state_r)
      ST_NORMAL, ST_TRI: begin
        if (hit_set)
          state_r <= ST_DIS;
        else if (low_now_r || lsf_s)
          state_r <= ST_TRI;
        else
          state_r <= ST_NORMAL;
      end
      ST_DIS: begin
        if (clr_wr && wdata[CLR_REINIT] && !count_hit_r)
          state_r <= ST_NORMAL;
      end
    endcase
  end

  // ****************************************
  // bridge drive
  // ****************************************
  logic run;
  logic ha, la, hb, lb;
  assign run = state_r == ST_NORMAL && !low_now_r && !lsf_s;
  always_comb begin
    // mode 0: direction on a, modulation on b; mode 1: independent
    if (drv_mode_r) begin
      ha = ina_s;
      la = !ina_s;
      hb = inb_s;
      lb = !inb_s;
    end else begin
      ha = inb_s && !ina_s;
      la = !ha;
      hb = inb_s && ina_s;
      lb = !hb;
    end
  end
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      hs_a      <= 1'b0;
      ls_a      <= 1'b0;
      hs_b      <= 1'b0;
      ls_b      <= 1'b0;
      bridge_en <= 1'b0;
    end else begin
      // all gates low whenever not running, so no leg floats half on
      hs_a      <= run & ha;
      ls_a      <= run & la;
      hs_b      <= run & hb;
      ls_b      <= run & lb;
      bridge_en <= run;
    end
  end
  // logic supply fault pulls disable pin low
  always_ff @(posedge mclk) begin
    if (sys_rst) dis_n_oe <= 1'b0;
    else         dis_n_oe <= lsf_s;
  end
  assign dis_n_out = 1'b0;

  // ****************************************
  // read port
  // ****************************************
  always_ff @(posedge mclk) begin
    if (sys_rst)
      rdata <= 32'h0;
    else if (rd) begin
      rdata <= 32'h0;
      if (addr == ADDR_CFG) begin
        rdata[CFG_WIN_BIT]   <= win_sel_r;
        rdata[CFG_GUARD_BIT] <= guard_en_r;
      end else if (addr == ADDR_DRIVE)
        rdata[DRV_MODE_BIT] <= drv_mode_r;
      else if (addr == ADDR_STATUS) begin
        rdata[ST_LOW_NOW]   <= low_now_r;
        rdata[ST_LOW_LATCH] <= low_latch_r;
        rdata[ST_COUNT_HIT] <= count_hit_r;
        rdata[ST_WIN_RB]    <= win_sel_r;
        rdata[ST_GUARD_RB]  <= guard_en_r;
        rdata[ST_DISABLED]  <= state_r == ST_DIS;
        rdata[ST_TRISTATE]  <= state_r == ST_TRI;
      end
    end else
      rdata <= 32'h0;
  end
endmodule : battery_undervoltage_monitor

// *** design/batt_mon_pkg.sv ***
// Function
// - normal mode drives bridge from selected scheme
// - tri-state on fault, auto resume
// - disabled state holds until host clears count hit and reinits
// - logic supply fault tri-states, pulls disable low
// - filtered low battery disables bridge
// - filter applies to both transitions
// - recovery resumes with current inputs, settings kept
// - unlatched low battery status readable
// - latched low battery flag readable
// - two events in window trip guard
// - host bit enables window guard
// - guard enable echoed back
// - host bit selects 20 or 40 us
// - window selection echoed back
// - count hit flag readable
// - guard off means unlimited tri-state cycling
// - short dips ignored entirely
package batt_mon_pkg;
  // ****************************************
  // register map
  // ****************************************
  localparam int        ADDR_W        = 4;
  localparam logic [3:0] ADDR_CFG     = 4'h0;
  localparam logic [3:0] ADDR_STATUS  = 4'h1;
  localparam logic [3:0] ADDR_CLEAR   = 4'h2;
  localparam logic [3:0] ADDR_DRIVE   = 4'h3;
  // cfg fields (command frame 4 positions)
  localparam int CFG_WIN_BIT    = 0;
  localparam int CFG_GUARD_BIT  = 3;
  // status fields
  localparam int ST_LOW_NOW     = 0;
  localparam int ST_LOW_LATCH   = 5;
  localparam int ST_COUNT_HIT   = 8;
  localparam int ST_WIN_RB      = 16;
  localparam int ST_GUARD_RB    = 19;
  localparam int ST_DISABLED    = 24;
  localparam int ST_TRISTATE    = 25;
  // clear / drive fields
  localparam int CLR_LOW_LATCH  = 0;
  localparam int CLR_COUNT_HIT  = 1;
  localparam int CLR_REINIT     = 2;
  localparam int DRV_MODE_BIT   = 0;
  // ****************************************
  // timing
  // ****************************************
  localparam int CLK_MHZ        = 100;
  localparam int FILT_TIME_NS   = 2000;
  localparam int WIN_SHORT_US   = 20;
  localparam int WIN_LONG_US    = 40;
  localparam int FILT_CYC       = FILT_TIME_NS * CLK_MHZ / 1000;
  localparam int WIN_SHORT_CYC  = WIN_SHORT_US * CLK_MHZ;
  localparam int WIN_LONG_CYC   = WIN_LONG_US * CLK_MHZ;
  typedef enum logic [1:0] {ST_NORMAL, ST_TRI, ST_DIS} bridge_state_t;
endpackage : batt_mon_pkg

// *** verif/batt_mon_checker.sv ***
`timescale 1ns/10ps
module batt_mon_checker
  import batt_mon_pkg::*;
(
  // watched ports
  input wire logic        mclk,
  input wire logic        sys_rst,
  input wire logic [3:0]  addr,
  input wire logic        rd,
  input wire logic [31:0] rdata,
  input wire logic        batt_low_cmp,
  input wire logic        logic_supply_fault,
  input wire logic        hs_a,
  input wire logic        ls_a,
  input wire logic        hs_b,
  input wire logic        ls_b,
  input wire logic        bridge_en,
  input wire logic        dis_n_out,
  input wire logic        dis_n_oe
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);
  // ****************************************
  // properties
  // ****************************************
  sequence s_st_read;
    (rd && addr == ADDR_STATUS) ##1 1'b1;
  endsequence
  sequence s_low_long;
    batt_low_cmp [*8] ##1 batt_low_cmp [*2];
  endsequence
  property p_low_kills;
    s_low_long |-> !bridge_en;
  endproperty
  property p_supply_pin;
    logic_supply_fault [*6] |-> dis_n_oe && !bridge_en;
  endproperty
  property p_pin_level;
    dis_n_out == 1'b0;
  endproperty
  property p_gates_off;
    !bridge_en |-> !(hs_a || ls_a || hs_b || ls_b);
  endproperty
  property p_no_shoot;
    !(hs_a && ls_a) && !(hs_b && ls_b);
  endproperty
  property p_unmapped;
    rd && addr > 4'h3 |=> rdata == 32'h0;
  endproperty
  property p_cfg_bits;
    rd && addr == ADDR_CFG |=> (rdata & ~32'h9) == 32'h0;
  endproperty
  property p_hit_dis;
    s_st_read |-> !rdata[ST_COUNT_HIT] || rdata[ST_DISABLED];
  endproperty
  a_low_kills:   assert property (p_low_kills)  else $error("low kept on");
  a_supply_pin:  assert property (p_supply_pin) else $error("pin not low");
  a_pin_level:   assert property (p_pin_level)  else $error("pin level");
  a_gates_off:   assert property (p_gates_off)  else $error("gate on");
  a_no_shoot:    assert property (p_no_shoot)   else $error("shoot thru");
  a_unmapped:    assert property (p_unmapped)   else $error("unmapped");
  a_cfg_bits:    assert property (p_cfg_bits)   else $error("cfg bits");
  a_hit_dis:     assert property (p_hit_dis)    else $error("hit free");
endmodule : batt_mon_checker

// *** verif/supply_model.sv ***
`timescale 1ns/10ps
module supply_model (
  // clock in, comparator outputs
  input  wire logic mclk,
  output logic      batt_low_cmp,
  output logic      logic_supply_fault
);
  initial batt_low_cmp = 1'b0;
  initial logic_supply_fault = 1'b0;
  // battery dip of n cycles, then n2 cycles of good supply
  task automatic dip(input int n, input int n2);
    @(posedge mclk) batt_low_cmp <= 1'b1;
    repeat (n) @(posedge mclk);
    batt_low_cmp <= 1'b0;
    repeat (n2) @(posedge mclk);
  endtask : dip
  task automatic fault(input int n);
    @(posedge mclk) logic_supply_fault <= 1'b1;
    repeat (n) @(posedge mclk);
    logic_supply_fault <= 1'b0;
  endtask : fault
endmodule : supply_model

// *** verif/testbench.sv ***
`timescale 1ns/10ps
module testbench;
  import batt_mon_pkg::*;
  logic mclk = 0, sys_rst = 1, wr = 0, rd = 0;
  logic [3:0]  addr = 4'h0;
  logic [31:0] wdata = 32'h0, rdata, got;
  logic hs_a, ls_a, hs_b, ls_b, bridge_en, dis_n_out, dis_n_oe, low, lsf;
  logic ina = 1'b1, inb = 1'b1, dis_n_pin = 1'b1;
  localparam logic [31:0] HIT_DIS = 32'h1000100;
  int failures = 0, tests_run = 0;
  localparam logic [31:0] LL = 32'h1 << ST_LOW_LATCH;
  localparam logic [31:0] GD = 32'h1 << ST_GUARD_RB;
  battery_undervoltage_monitor #(.FILT_CYCLES(4), .WIN_S_CYC(20),
    .WIN_L_CYC(40)) DUT (.mclk(mclk), .sys_rst(sys_rst), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .batt_low_cmp(low),
    .logic_supply_fault(lsf), .drive_input_a(ina), .drive_input_b(inb),
    .hs_a(hs_a), .ls_a(ls_a), .hs_b(hs_b), .ls_b(ls_b),
    .bridge_en(bridge_en), .dis_n_in(dis_n_pin), .dis_n_out(dis_n_out),
    .dis_n_oe(dis_n_oe));
  supply_model sup (.mclk(mclk), .batt_low_cmp(low), .logic_supply_fault(lsf));
  initial forever #5 mclk = ~mclk;
  // ****************************************
  // bus and compare
  // ****************************************
  task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
    @(posedge mclk) {wr, addr, wdata} <= {1'b1, a, d};
    @(posedge mclk) wr <= 1'b0;
  endtask : wr_reg
  task automatic chk_reg(input logic [3:0] a, input logic [31:0] e);
    @(posedge mclk) {rd, addr} <= {1'b1, a};
    @(posedge mclk) rd <= 1'b0;
    #1 tests_run++;
    if (rdata !== e) begin
      failures++;
      $display("ERROR t=%0t got=%h exp=%h", $time, rdata, e);
    end
  endtask : chk_reg
  // gate commands as {hs_a, ls_a, hs_b, ls_b, bridge_en}
  task automatic chk_out(input logic [4:0] e);
    #1 tests_run++;
    if ({hs_a, ls_a, hs_b, ls_b, bridge_en} !== e) begin
      failures++;
      $display("ERROR t=%0t got=%h exp=%h", $time,
               {hs_a, ls_a, hs_b, ls_b, bridge_en}, e);
    end
  endtask : chk_out
  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_defaults;
    chk_reg(ADDR_CFG, 32'h0);
    chk_reg(ADDR_STATUS, 32'h0);
    chk_reg(4'hF, 32'h0);
    wr_reg(ADDR_CFG, 32'h9);
    chk_reg(ADDR_STATUS, GD | 32'h10000);
    wr_reg(ADDR_CFG, 32'h0);
    $display("defaults done");
  endtask : t_defaults
  task automatic t_drive;
    @(posedge mclk);
    ina <= 1'b1;
    inb <= 1'b1;
    repeat (6) @(posedge mclk);
    chk_out(5'b01101);
    wr_reg(ADDR_DRIVE, 32'h1);
    chk_reg(ADDR_DRIVE, 32'h1);
    @(posedge mclk);
    inb <= 1'b0;
    repeat (6) @(posedge mclk);
    chk_out(5'b10011);
    @(posedge mclk);
    inb <= 1'b1;
    wr_reg(ADDR_DRIVE, 32'h0);
    repeat (6) @(posedge mclk);
    chk_out(5'b01101);
    $display("drive done");
  endtask : t_drive
  task automatic t_dips_unguarded;
    sup.dip(3, 10);
    chk_reg(ADDR_STATUS, 32'h0);
    fork
      sup.dip(20, 10);
      begin
        repeat (14) @(posedge mclk);
        chk_reg(ADDR_STATUS, LL | 32'h2000001);
      end
    join
    sup.dip(8, 10);
    chk_reg(ADDR_STATUS, LL);
    wr_reg(ADDR_CLEAR, 32'h1);
    chk_reg(ADDR_STATUS, 32'h0);
    $display("unguarded done");
  endtask : t_dips_unguarded
  task automatic t_guard_trip;
    wr_reg(ADDR_CFG, 32'h8);
    sup.dip(8, 8);
    sup.dip(8, 20);
    chk_reg(ADDR_STATUS, LL | GD | 32'h1000100);
    wr_reg(ADDR_CLEAR, 32'h3);
    chk_reg(ADDR_STATUS, GD | 32'h1000000);
    wr_reg(ADDR_CLEAR, 32'h4);
    chk_reg(ADDR_STATUS, GD);
    $display("guard done");
  endtask : t_guard_trip
  task automatic t_window_expiry;
    wr_reg(ADDR_CFG, 32'h9);
    sup.dip(8, 50);
    sup.dip(8, 20);
    chk_reg(ADDR_STATUS, LL | GD | 32'h10000);
    wr_reg(ADDR_CFG, 32'h0);
    wr_reg(ADDR_CLEAR, 32'h1);
    wr_reg(ADDR_CFG, 32'h9);
    sup.dip(8, 20);
    sup.dip(8, 20);
    chk_reg(ADDR_STATUS, LL | GD | 32'h10000 | HIT_DIS);
    wr_reg(ADDR_CLEAR, 32'h3);
    wr_reg(ADDR_CLEAR, 32'h4);
    wr_reg(ADDR_CFG, 32'h8);
    sup.dip(8, 20);
    sup.dip(8, 20);
    chk_reg(ADDR_STATUS, LL | GD);
    wr_reg(ADDR_CLEAR, 32'h1);
    wr_reg(ADDR_CFG, 32'h0);
    $display("window done");
  endtask : t_window_expiry
  task automatic t_supply_fault;
    fork
      sup.fault(12);
      begin
        repeat (8) @(posedge mclk);
        #1 tests_run++;
        if (dis_n_oe !== 1'b1 || bridge_en !== 1'b0) begin
          failures++;
          $display("ERROR t=%0t got=%h exp=%h", $time, dis_n_oe, 1'b1);
        end
      end
    join
    $display("supply fault done");
  endtask : t_supply_fault
  task automatic test_done;
    $display("tests_run=%0d failures=%0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : test_done
  initial begin
    repeat (20) @(posedge mclk);
    sys_rst <= 1'b0;
    t_defaults;
    t_drive;
    t_dips_unguarded;
    t_guard_trip;
    t_window_expiry;
    t_supply_fault;
    test_done;
  end
  initial begin
    repeat (5000) @(posedge mclk);
    failures++;
    test_done;
  end
endmodule : testbench
bind battery_undervoltage_monitor batt_mon_checker u_chk (.mclk(mclk),
  .sys_rst(sys_rst), .addr(addr), .rd(rd), .rdata(rdata),
  .batt_low_cmp(batt_low_cmp), .logic_supply_fault(logic_supply_fault),
  .hs_a(hs_a), .ls_a(ls_a), .hs_b(hs_b), .ls_b(ls_b),
  .bridge_en(bridge_en), .dis_n_out(dis_n_out), .dis_n_oe(dis_n_oe));
